// ==== pkg/cgpd_params.svh ====
// Offsets, field positions, reset values and timing counts of the clock unit
`ifndef CGPD_PARAMS_SVH
`define CGPD_PARAMS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define CGPD_CLK_MHZ 125
`define CGPD_RING_MHZ 232
`define CGPD_OSC_DIV 64
`define CGPD_OSC_HALF ((`CGPD_OSC_DIV * `CGPD_CLK_MHZ) / (2 * `CGPD_RING_MHZ))
`define CGPD_LOCK_WIN 8'h04
`define CGPD_LOCK_CNT 4'h8

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define CGPD_OFS_CTRL 12'h000
`define CGPD_OFS_PRE 12'h004
`define CGPD_OFS_FB 12'h008
`define CGPD_OFS_STAT 12'h00c
`define CGPD_OFS_TUNE 12'h010
`define CGPD_OFS_POST0 12'h020

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CGPD_CTRL_RUN 0
`define CGPD_CTRL_SEL 1
`define CGPD_POST_CNT 0
`define CGPD_POST_HIGH 10
`define CGPD_POST_NONEVEN 18
`define CGPD_POST_PHASE 20

// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define CGPD_CNT_RST 10'h001
`define CGPD_CNT_MAX_EVEN 10'h200
`define CGPD_CNT_MAX_ODD 10'h100
`define CGPD_TUNE_RST 16'h1000
`define CGPD_TUNE_MIN 16'h0001
`define CGPD_TUNE_MAX 16'hffff
`define CGPD_TUNE_STEP 16'h0001

`endif

// ==== pkg/cgpd_pkg.sv ====
// Types shared by the clock unit
package cgpd_pkg;

  typedef enum logic [1:0] {
    PFD_IDLE = 2'b00,
    PFD_UP = 2'b01,
    PFD_DOWN = 2'b10
  } cgpd_pfd_t;

endpackage : cgpd_pkg

// ==== hw/cgpd_post_div.sv ====
// Post-scale divider counting eighth-period ticks of the controlled oscillator
`timescale 1ns/10ps
module cgpd_post_div (
  input wire logic clk_sys, // System clock
  input wire logic rstN, // Synchronised reset, active low
  input wire logic restart, // Loop held in reset
  input wire logic tick, // One eighth of an oscillator period
  input wire logic [9:0] divCount, // Division count 1..512
  input wire logic [7:0] highCount, // High periods for non-even duty
  input wire logic nonEven, // Non-even duty selected
  input wire logic [2:0] phaseStep, // Phase offset in eighths
  output logic divClk, // Divided clock
  output logic divFall // Pulse on the edge where divClk falls
);

  logic [11:0] pos_q;
  logic clk_q;
  logic [11:0] posNext;
  logic [12:0] period;
  logic [12:0] highLen;
  logic nextLevel;

  // ----------------------------------------
  // Counting
  // ----------------------------------------
  // output is oscillator over count
  assign period = {divCount, 3'b000};
  assign highLen = nonEven ? {2'b00, highCount, 3'b000} : {1'b0, divCount, 2'b00};
  assign posNext = (({1'b0, pos_q} + 13'h0001) >= period) ? 12'h000 : pos_q + 12'h001;
  assign nextLevel = {1'b0, posNext} < highLen;

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      pos_q <= 12'h000;
      clk_q <= 1'b0;
    end else if (restart) begin
      pos_q <= {9'h000, phaseStep};
      clk_q <= 1'b0;
    end else if (tick) begin
      pos_q <= posNext;
      clk_q <= nextLevel;
    end
  end

  assign divClk = clk_q;
  assign divFall = tick & ~restart & clk_q & ~nextLevel;

endmodule : cgpd_post_div

// ==== hw/cgpd_clock_unit.sv ====
// Clock unit: gated global nets, ring oscillator and digital synthesizer loop
`timescale 1ns/10ps
`include "cgpd_params.svh"

module cgpd_clock_unit #(
  parameter int INST_ID = 1 // Synthesizer instance number
) (
  input wire logic clk_sys, // System clock, 125 MHz
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic [11:0] paddr, // APB address
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic [3:0] refClkPin, // Reference clock pins
  input wire logic [4:0] gateEn, // Network gate enables from fabric
  input wire logic extGateEn, // Dedicated pin gate enable
  input wire logic oscEnable, // Internal oscillator enable
  output logic [4:0] globalClockNet, // Gated network clocks
  output logic extClkOut, // Dedicated external clock output
  output logic converterClk, // Converter clock
  output logic oscClkOut, // Internal oscillator clock
  output logic locked, // Loop locked
  output logic pfdUp, // Detector up indication
  output logic pfdDown // Detector down indication
);

  // ----------------------------------------
  // Reset and pin synchronisers
  // ----------------------------------------
  logic rstMeta_q, rstSync_q;
  logic [3:0] refMeta_q, refSync_q, refPrev_q;
  logic rstN;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end
  assign rstN = rstSync_q;

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      refMeta_q <= 4'h0;
      refSync_q <= 4'h0;
      refPrev_q <= 4'h0;
    end else begin
      refMeta_q <= refClkPin;
      refSync_q <= refMeta_q;
      refPrev_q <= refSync_q;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic run_q;
  logic [1:0] refSel_q;
  logic [9:0] preDiv_q, fbDiv_q;
  logic [15:0] tune_q;
  logic [31:0] prdata_q;
  logic [4:0][31:0] postWord;
  logic [11:0] postOfs;
  logic isPost, apbWr, badWr, cntOk;
  logic [9:0] wrCnt;

  assign postOfs = paddr - `CGPD_OFS_POST0;
  assign isPost = (postOfs[11:2] < 10'h005) && (postOfs[1:0] == 2'b00);
  assign wrCnt = pwdata[`CGPD_POST_CNT +: 10];

  always_comb begin
    cntOk = (wrCnt != 10'h000) && (wrCnt <= `CGPD_CNT_MAX_EVEN);
    if (isPost && pwdata[`CGPD_POST_NONEVEN]) begin
      cntOk = cntOk && (wrCnt <= `CGPD_CNT_MAX_ODD);
    end
  end

  always_comb begin
    badWr = 1'b0;
    unique case (paddr)
      `CGPD_OFS_CTRL, `CGPD_OFS_STAT, `CGPD_OFS_TUNE: badWr = 1'b0;
      `CGPD_OFS_PRE, `CGPD_OFS_FB: badWr = pwrite && !cntOk;
      default: badWr = isPost ? (pwrite && !cntOk) : 1'b1;
    endcase
  end

  assign pready = 1'b1;
  assign pslverr = psel && penable && badWr;
  assign apbWr = psel && penable && pwrite && !badWr;
  assign prdata = prdata_q;

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      run_q <= 1'b0;
      refSel_q <= 2'b00;
      preDiv_q <= `CGPD_CNT_RST;
      fbDiv_q <= `CGPD_CNT_RST;
    end else if (apbWr) begin
      if (paddr == `CGPD_OFS_CTRL) begin
        run_q <= pwdata[`CGPD_CTRL_RUN];
        refSel_q <= pwdata[`CGPD_CTRL_SEL +: 2];
      end
      if (paddr == `CGPD_OFS_PRE) begin
        preDiv_q <= wrCnt;
      end
      if (paddr == `CGPD_OFS_FB) begin
        fbDiv_q <= wrCnt;
      end
    end
  end

  // Read data is captured in the setup cycle so it stands registered in the access cycle
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        `CGPD_OFS_CTRL: prdata_q <= {29'h0, refSel_q, run_q};
        `CGPD_OFS_PRE: prdata_q <= {22'h0, preDiv_q};
        `CGPD_OFS_FB: prdata_q <= {22'h0, fbDiv_q};
        `CGPD_OFS_STAT: prdata_q <= {29'h0, pfdDown, pfdUp, locked};
        `CGPD_OFS_TUNE: prdata_q <= {16'h0, tune_q};
        default: prdata_q <= isPost ? postWord[postOfs[4:2]] : 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // Reference path
  // ----------------------------------------
  logic refRise, refEv, fbEv;
  logic [9:0] preCnt_q, fbCnt_q;

  assign refRise = refSync_q[refSel_q] & ~refPrev_q[refSel_q];
  assign refEv = run_q && refRise && (preCnt_q == preDiv_q - 10'h001);

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      preCnt_q <= 10'h000;
    end else if (!run_q || refEv) begin
      preCnt_q <= 10'h000;
    end else if (refRise) begin
      preCnt_q <= preCnt_q + 10'h001;
    end
  end

  // ----------------------------------------
  // Controlled oscillator and feedback
  // ----------------------------------------
  // Accumulator carries mark eighths of the oscillator period, so phase steps come for free
  logic [15:0] acc_q;
  logic [16:0] accSum;
  logic [2:0] eighth_q;
  logic tick, oscRise;

  assign accSum = {1'b0, acc_q} + {1'b0, tune_q};
  assign tick = run_q & accSum[16];
  assign oscRise = tick && (eighth_q == 3'h7);

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      acc_q <= 16'h0000;
      eighth_q <= 3'h0;
    end else if (!run_q) begin
      acc_q <= 16'h0000;
      eighth_q <= 3'h0;
    end else begin
      acc_q <= accSum[15:0];
      if (tick) begin
        eighth_q <= eighth_q + 3'h1;
      end
    end
  end

  assign fbEv = oscRise && (fbCnt_q == fbDiv_q - 10'h001);

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      fbCnt_q <= 10'h000;
    end else if (!run_q || fbEv) begin
      fbCnt_q <= 10'h000;
    end else if (oscRise) begin
      fbCnt_q <= fbCnt_q + 10'h001;
    end
  end

  // ----------------------------------------
  // Phase detector, tuning and lock
  // ----------------------------------------
  cgpd_pkg::cgpd_pfd_t pfd_q;
  logic [7:0] errCnt_q;
  logic [3:0] lockCnt_q;

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      pfd_q <= cgpd_pkg::PFD_IDLE;
    end else if (!run_q) begin
      pfd_q <= cgpd_pkg::PFD_IDLE;
    end else begin
      unique case (pfd_q)
        cgpd_pkg::PFD_IDLE: begin
          if (refEv && !fbEv) begin
            pfd_q <= cgpd_pkg::PFD_UP;
          end else if (fbEv && !refEv) begin
            pfd_q <= cgpd_pkg::PFD_DOWN;
          end
        end
        cgpd_pkg::PFD_UP: begin
          if (fbEv && !refEv) begin
            pfd_q <= cgpd_pkg::PFD_IDLE;
          end
        end
        cgpd_pkg::PFD_DOWN: begin
          if (refEv && !fbEv) begin
            pfd_q <= cgpd_pkg::PFD_IDLE;
          end
        end
        default: pfd_q <= cgpd_pkg::PFD_IDLE;
      endcase
    end
  end

  assign pfdUp = (pfd_q == cgpd_pkg::PFD_UP);
  assign pfdDown = (pfd_q == cgpd_pkg::PFD_DOWN);

  // Tuning saturates so a wild setting can never wrap the oscillator to the opposite extreme
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      tune_q <= `CGPD_TUNE_RST;
    end else if (pfdUp && tune_q != `CGPD_TUNE_MAX) begin
      tune_q <= tune_q + `CGPD_TUNE_STEP;
    end else if (pfdDown && tune_q != `CGPD_TUNE_MIN) begin
      tune_q <= tune_q - `CGPD_TUNE_STEP;
    end
  end

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      errCnt_q <= 8'h00;
      lockCnt_q <= 4'h0;
    end else if (!run_q) begin
      errCnt_q <= 8'h00;
      lockCnt_q <= 4'h0;
    end else begin
      if (pfd_q == cgpd_pkg::PFD_IDLE) begin
        errCnt_q <= 8'h00;
      end else if (errCnt_q != 8'hff) begin
        errCnt_q <= errCnt_q + 8'h01;
      end
      if (refEv) begin
        if (errCnt_q > `CGPD_LOCK_WIN) begin
          lockCnt_q <= 4'h0;
        end else if (lockCnt_q != `CGPD_LOCK_CNT) begin
          lockCnt_q <= lockCnt_q + 4'h1;
        end
      end
    end
  end

  assign locked = (lockCnt_q == `CGPD_LOCK_CNT);

  // ----------------------------------------
  // Post dividers and network gates
  // ----------------------------------------
  logic [4:0] postClk, postFall;
  logic extStage1_q, extStage2_q;

  for (genvar i = 0; i < 5; i++) begin : g_post
    logic [9:0] cnt_q;
    logic [7:0] high_q;
    logic nonEven_q, gate_q;
    logic [2:0] phase_q;

    always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
        cnt_q <= `CGPD_CNT_RST;
        high_q <= 8'h00;
        nonEven_q <= 1'b0;
        phase_q <= 3'h0;
      end else if (apbWr && isPost && postOfs[4:2] == 3'(i)) begin
        cnt_q <= wrCnt;
        high_q <= pwdata[`CGPD_POST_HIGH +: 8];
        nonEven_q <= pwdata[`CGPD_POST_NONEVEN];
        phase_q <= pwdata[`CGPD_POST_PHASE +: 3];
      end
    end

    assign postWord[i] = {9'h0, phase_q, 1'b0, nonEven_q, high_q, cnt_q};

    cgpd_post_div u_div (
      .clk_sys(clk_sys),
      .rstN(rstN),
      .restart(!run_q),
      .tick(tick),
      .divCount(cnt_q),
      .highCount(high_q),
      .nonEven(nonEven_q),
      .phaseStep(phase_q),
      .divClk(postClk[i]),
      .divFall(postFall[i])
    );

    always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
        gate_q <= 1'b0;
      end else if (postFall[i]) begin
        gate_q <= gateEn[i];
      end
    end

    // divider keeps running; a re-enable takes effect at the next fall of the divided clock
    assign globalClockNet[i] = postClk[i] & gate_q;
  end

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      extStage1_q <= 1'b0;
      extStage2_q <= 1'b0;
    end else if (postFall[0]) begin
      extStage1_q <= extGateEn;
      extStage2_q <= extStage1_q;
    end
  end

  assign extClkOut = postClk[0] & extStage2_q;

  // converter clock from instances one and three
  assign converterClk = (INST_ID == 1 || INST_ID == 3) ? postClk[0] : 1'b0;

  // ----------------------------------------
  // Internal ring oscillator
  // ----------------------------------------
  logic [7:0] oscCnt_q;
  logic oscHalf_q;

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      oscCnt_q <= 8'h00;
      oscHalf_q <= 1'b1;
    end else if (!oscEnable) begin
      oscCnt_q <= 8'h00;
      oscHalf_q <= 1'b1;
    end else if (oscCnt_q == 8'(`CGPD_OSC_HALF - 1)) begin
      oscCnt_q <= 8'h00;
      oscHalf_q <= ~oscHalf_q;
    end else begin
      oscCnt_q <= oscCnt_q + 8'h01;
    end
  end

  assign oscClkOut = ~oscEnable | oscHalf_q;

endmodule : cgpd_clock_unit

// ==== dv/cgpd_fabric_model.sv ====
// Fabric-side model driving the reference clock pins
`timescale 1ns/10ps
module cgpd_fabric_model #(
  parameter realtime HALF0 = 512.0 // Half period of pin 0 in ns
) (
  output logic [3:0] refClkPin // Reference clock pins
);
  // ----------------------------------------
  // Reference pins
  // ----------------------------------------
  // Clock pins run free; only the selected one matters to the loop
  for (genvar i = 0; i < 4; i++) begin : g_pin
    initial begin
      refClkPin[i] = 1'b0;
      forever #(HALF0 * (i + 1)) refClkPin[i] = ~refClkPin[i];
    end
  end
endmodule : cgpd_fabric_model

// ==== dv/cgpd_clock_unit_checker.sv ====
// Concurrent checks on the clock unit ports
`timescale 1ns/10ps
module cgpd_clock_unit_checker #(
  parameter int INST_ID = 1 // Synthesizer instance number
) (
  input wire logic clk_sys, // System clock
  input wire logic rst_n, // Reset, active low
  input wire logic oscEnable, // Oscillator enable
  input wire logic [4:0] globalClockNet, // Gated network clocks
  input wire logic extClkOut, // Dedicated output
  input wire logic converterClk, // Converter clock
  input wire logic oscClkOut, // Oscillator clock
  input wire logic pfdUp, // Detector up
  input wire logic pfdDown // Detector down
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // Oscillator
  // ----------------------------------------
  osc_idle_a: assert property (!oscEnable |-> oscClkOut)
    else $error("oscillator output low while disabled");
  osc_start_a: assert property ($rose(oscEnable) |-> oscClkOut [*8])
    else $error("oscillator output fell too soon after enable");
  osc_low_a: assert property ($fell(oscClkOut) |-> (!oscClkOut || !oscEnable) [*8])
    else $error("oscillator low phase too short");
  // ----------------------------------------
  // Detector and gates
  // ----------------------------------------
  pfd_excl_a: assert property (!(pfdUp && pfdDown))
    else $error("detector up and down together");
  net_rise_a: assert property ($rose(globalClockNet[0]) |-> $rose(converterClk))
    else $error("gated net rose off the divider edge");
  net_fall_a: assert property ($fell(globalClockNet[0]) |-> $fell(converterClk))
    else $error("gated net high phase truncated");
  ext_rise_a: assert property ($rose(extClkOut) |-> $rose(converterClk))
    else $error("external output rose off the divider edge");
  ext_fall_a: assert property ($fell(extClkOut) |-> $fell(converterClk))
    else $error("external output high phase truncated");
  conv_src_a: assert property (globalClockNet[0] |-> converterClk)
    else $error("converter clock not from first output");
endmodule : cgpd_clock_unit_checker

// ==== dv/testbench.sv ====
// Self-checking bench for the clock unit
`timescale 1ns/10ps
`include "cgpd_params.svh"
module testbench;
  logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, extGateEn, oscEnable;
  logic extClkOut, converterClk, oscClkOut, locked, pfdUp, pfdDown;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] refClkPin, mon;
  logic [4:0] gateEn, globalClockNet;
  int nMismatch, compares, cyc;
  assign mon = {oscClkOut, globalClockNet[0], extClkOut, converterClk};
  cgpd_fabric_model u_far (.refClkPin(refClkPin));
  cgpd_clock_unit #(.INST_ID(1)) u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .refClkPin(refClkPin), .gateEn(gateEn), .extGateEn(extGateEn),
    .oscEnable(oscEnable), .globalClockNet(globalClockNet), .extClkOut(extClkOut),
    .converterClk(converterClk), .oscClkOut(oscClkOut), .locked(locked), .pfdUp(pfdUp),
    .pfdDown(pfdDown));
  // ----------------------------------------
  // Clock, timeout and shared tasks
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      nMismatch++;
      end_sim;
    end
  end
  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, nMismatch);
    if (nMismatch == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      nMismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // One transfer; entered just after a rising edge, leaves one idle cycle
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd,
    output logic er);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // This wait ends once pready is high, which the unit ties high
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  // Waits for a rise of mon[b], counting falls of the first divider meanwhile
  task automatic wait_rise(input int b, output int falls, output int n);
    logic [3:0] p;
    p = mon;
    falls = 0;
    n = 0;
    forever begin
      @(posedge clk_sys);
      n++;
      if (p[0] === 1'b1 && mon[0] === 1'b0) falls++;
      if ((p[b] === 1'b0 && mon[b] === 1'b1) || n > 3000) break;
      p = mon;
    end
  endtask : wait_rise
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    logic [31:0] d;
    logic e;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, `CGPD_OFS_POST0 + 12'(4 * i), 32'h0, d, e);
      chk("post reset", d, 32'h1);
    end
    apb(1'b0, `CGPD_OFS_PRE, 32'h0, d, e);
    chk("pre reset", d, 32'h1);
    apb(1'b0, `CGPD_OFS_FB, 32'h0, d, e);
    chk("fb reset", d, 32'h1);
    apb(1'b1, `CGPD_OFS_PRE, 32'h0, d, e);
    chk("pre zero", e, 1'b1);
    apb(1'b0, `CGPD_OFS_STAT, 32'h0, d, e);
    chk("stat idle", d, 32'h0);
    chk("detector idle", {pfdDown, pfdUp, locked}, 32'h0);
    apb(1'b1, 12'h040, 32'h5, d, e);
    chk("unmapped err", e, 1'b1);
    apb(1'b0, 12'h040, 32'h0, d, e);
    chk("unmapped data", d, 32'h0);
    apb(1'b1, `CGPD_OFS_CTRL, 32'h6, d, e);
    apb(1'b0, `CGPD_OFS_CTRL, 32'h0, d, e);
    chk("ref select", d, 32'h6);
    apb(1'b1, `CGPD_OFS_CTRL, 32'h0, d, e);
  endtask : t_regs
  task automatic t_limits;
    logic [31:0] v[5] = '{32'h200, 32'h201, 32'h0, 32'h40100, 32'h40101};
    logic [4:0] bad = 5'b10110;
    logic [31:0] last, d;
    logic e;
    last = 32'h1;
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, `CGPD_OFS_POST0 + 12'h004, v[i], d, e);
      chk("post err", e, bad[i]);
      if (!bad[i]) last = v[i];
      apb(1'b0, `CGPD_OFS_POST0 + 12'h004, 32'h0, d, e);
      chk("post hold", d, last);
    end
    apb(1'b1, `CGPD_OFS_POST0 + 12'h004, 32'h2, d, e);
  endtask : t_limits
  task automatic t_osc;
    int f, n;
    chk("osc idle", oscClkOut, 1'b1);
    oscEnable <= 1'b1;
    wait_rise(3, f, n);
    wait_rise(3, f, n);
    chk("osc period", n, 2 * `CGPD_OSC_HALF);
    oscEnable <= 1'b0;
    @(posedge clk_sys);
    @(posedge clk_sys);
    chk("osc off", oscClkOut, 1'b1);
  endtask : t_osc
  task automatic t_ratio;
    int r[5];
    int f, n;
    logic [4:0] p;
    logic [31:0] d;
    logic e;
    apb(1'b1, `CGPD_OFS_CTRL, 32'h1, d, e);
    wait_rise(0, f, n);
    r = '{default: 0};
    p = globalClockNet;
    repeat (4000) begin
      @(posedge clk_sys);
      for (int i = 0; i < 5; i++) if (!p[i] && globalClockNet[i]) r[i]++;
      p = globalClockNet;
    end
    chk("ratio", (r[0] - 2 * r[1]) inside {[-1:1]}, 1'b1);
    chk("slow net runs", r[1] > 2, 1'b1);
    chk("fifth net", (r[4] - r[0]) inside {[-1:1]}, 1'b1);
  endtask : t_ratio
  task automatic t_gates;
    int f, n;
    wait_rise(0, f, n);
    gateEn <= 5'h1e;
    extGateEn <= 1'b1;
    wait_rise(1, f, n);
    chk("ext falls", f, 2);
    wait_rise(0, f, n);
    repeat (4) @(posedge clk_sys);
    chk("net off", globalClockNet[0], 1'b0);
    gateEn <= 5'h1f;
    wait_rise(2, f, n);
    chk("net falls", f, 1);
  endtask : t_gates
  // Third output offset by four eighths runs as the inverse of the first
  task automatic t_phase;
    int f, n;
    logic [31:0] d;
    logic e;
    apb(1'b1, `CGPD_OFS_POST0 + 12'h008, 32'h0040_0001, d, e);
    apb(1'b1, `CGPD_OFS_CTRL, 32'h0, d, e);
    apb(1'b1, `CGPD_OFS_CTRL, 32'h1, d, e);
    wait_rise(0, f, n);
    repeat (8) begin
      repeat (20) @(posedge clk_sys);
      chk("phase half", globalClockNet[2], !globalClockNet[0]);
    end
  endtask : t_phase
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    gateEn = 5'h1f;
    extGateEn = 1'b0;
    oscEnable = 1'b0;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_regs;
    t_limits;
    t_osc;
    t_ratio;
    t_gates;
    t_phase;
    end_sim;
  end
endmodule : testbench
bind cgpd_clock_unit cgpd_clock_unit_checker #(.INST_ID(INST_ID)) u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
  .oscEnable(oscEnable), .globalClockNet(globalClockNet), .extClkOut(extClkOut),
  .converterClk(converterClk), .oscClkOut(oscClkOut), .pfdUp(pfdUp), .pfdDown(pfdDown));
